// ==== dipi_pkg.sv ====
// Purpose: Shared constants and types for the digital input process image
// Assumes: APB slave with 32-bit data, byte-wide image registers
// Notes:   Each register takes one aligned word, data in the low byte
`default_nettype none
package dipi_pkg;

  // Register byte addresses
  localparam logic [7:0] OFS_TWO_IN      = 8'h00;
  localparam logic [7:0] OFS_TWO_ACK     = 8'h04;
  localparam logic [7:0] OFS_FOUR_IN     = 8'h08;
  localparam logic [7:0] OFS_EIGHT_IN    = 8'h0C;
  localparam logic [7:0] OFS_SNS_STATE   = 8'h10;
  localparam logic [7:0] OFS_SNS_FAULT   = 8'h14;
  localparam logic [7:0] OFS_SNS_RSVD    = 8'h18;
  localparam logic [7:0] OFS_SNS_OFF     = 8'h1C;
  localparam logic [7:0] OFS_ANALOG_LEN  = 8'h20;
  localparam logic [7:0] OFS_DIG_BASE    = 8'h24;

  // Field positions in the two-channel bytes
  localparam int POS_TWO_LEVEL = 0;
  localparam int POS_TWO_FLAG  = 2;
  localparam int POS_TWO_ACK   = 2;

  // Reset values
  localparam logic [1:0]  RST_TWO_ACK    = 2'h0;
  localparam logic [7:0]  RST_SNS_OFF    = 8'h00;
  localparam logic [7:0]  RST_ANALOG_LEN = 8'h00;
  localparam logic [31:0] RST_PRDATA     = 32'h0000_0000;

  // Number of digital image bytes that follow the analog data
  localparam logic [7:0] DIG_IMAGE_BYTES = 8'h06;

  // Per-channel diagnostic state, one-hot
  typedef enum logic [2:0] {
    CH_RUN   = 3'b001,
    CH_FAULT = 3'b010,
    CH_WACK  = 3'b100
  } dipi_chst_t;

endpackage : dipi_pkg
`default_nettype wire

// ==== dipi_chan_if.sv ====
// Purpose: Carrier between the image top and one diagnostic channel
// Assumes: All signals on sys_clk, inputs already synchronised
// Notes:   Host side drives pin state and acknowledge
`default_nettype none
interface dipi_chan_if;
  logic faultIn;
  logic levelIn;
  logic ackIn;
  logic flag;
  logic levelOut;
  logic active;

  modport chan (input faultIn, levelIn, ackIn,
                output flag, levelOut, active);
  modport host (output faultIn, levelIn, ackIn,
                input flag, levelOut, active);
endinterface : dipi_chan_if
`default_nettype wire

// ==== dipi_diag_chan.sv ====
// Purpose: Fault latch and acknowledge handshake for one input channel
// Assumes: Synchronised fault and level inputs, level acknowledge
// Notes:   A new fault beats an acknowledge in the same cycle
`default_nettype none
module dipi_diag_chan
  import dipi_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic reset_n,
  // Channel carrier
  dipi_chan_if.chan ch
);

  dipi_chst_t state_ff;
  dipi_chst_t nxt_state;

  // Fault latches at once; release needs fault gone and acknowledge
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      CH_RUN: begin
        if (ch.faultIn) begin
          nxt_state = CH_FAULT;
        end
      end
      CH_FAULT: begin
        if (!ch.faultIn) begin
          nxt_state = CH_WACK;
        end
      end
      CH_WACK: begin
        if (ch.faultIn) begin
          nxt_state = CH_FAULT;                      // Set wins over ack
        end else if (ch.ackIn) begin
          nxt_state = CH_RUN;
        end
      end
      default: begin
        nxt_state = CH_FAULT;                        // Illegal code is safe
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_ff <= CH_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Flag stays up until acknowledged; level is held low meanwhile
  assign ch.flag     = (state_ff != CH_RUN);
  assign ch.active   = (state_ff == CH_RUN);
  assign ch.levelOut = ch.levelIn & (state_ff == CH_RUN);

endmodule : dipi_diag_chan
`default_nettype wire

// ==== dipi_top.sv ====
// Purpose: APB-mapped process image of the digital input module family
// Assumes: Pins asynchronous to sys_clk, APB master on sys_clk
// Notes:   Every register answers after one wait state
`default_nettype none
// Notes on behaviour
// - Two-channel module latches flag on fault
// - Input re-activates only after acknowledge, fault gone
// - One flag, one acknowledge per channel
// - Levels bits 0-1, flags bits 2-3
// - Acknowledges bits 2-3, bits 0-1 zero
// - Four-channel levels bits 0-3, upper zero
// - Eight-channel levels fill bits 0-7
// - Sensor module: two input, two output bytes
// - Sensor signal state in first input byte
// - Sensor wire-break/short faults in second byte
// - Second output byte bit set switches channel off
// - Digital bytes follow all analog image data
module dipi_top
  import dipi_pkg::*;
(
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Two-channel diagnostic module pins
  input  wire logic [1:0]  twoChLevel,
  input  wire logic [1:0]  twoChFault,
  output logic      [1:0]  twoChActive,
  // Plain four- and eight-channel module pins
  input  wire logic [3:0]  fourChLevel,
  input  wire logic [7:0]  eightChLevel,
  // Sensor-input module pins
  input  wire logic [7:0]  sensorLevel,
  input  wire logic [7:0]  sensorFault,
  output logic      [7:0]  sensorChanOn
);

  // Synchroniser stages, all pins in one vector
  localparam int SYNC_W = 32;                       // Sum of all input pin widths
  logic [SYNC_W-1:0] syncA_ff;
  logic [SYNC_W-1:0] syncB_ff;
  logic [SYNC_W-1:0] nxt_syncA;
  logic [SYNC_W-1:0] nxt_syncB;

  // Synchronised pin views
  logic [1:0] twoLvlS;
  logic [1:0] twoFltS;
  logic [3:0] fourLvlS;
  logic [7:0] eightLvlS;
  logic [7:0] snsLvlS;
  logic [7:0] snsFltS;

  // Software state
  logic [1:0] ack_ff;
  logic [1:0] nxt_ack;
  logic [7:0] chanOff_ff;
  logic [7:0] nxt_chanOff;
  logic [7:0] analogLen_ff;
  logic [7:0] nxt_analogLen;

  // Bus answer state
  logic [31:0] prdata_ff;
  logic [31:0] nxt_prdata;
  logic        pready_ff;
  logic        nxt_pready;
  logic        pslverr_ff;
  logic        nxt_pslverr;

  // Pin outputs
  logic [1:0] twoActive_ff;
  logic [1:0] nxt_twoActive;
  logic [7:0] chanOn_ff;
  logic [7:0] nxt_chanOn;

  // Channel results
  logic [1:0] twoFlag;
  logic [1:0] twoLvlOut;
  logic [1:0] twoAct;

  // Image bytes and decode
  logic [7:0] twoInByte;
  logic [7:0] fourInByte;
  logic [7:0] eightInByte;
  logic [7:0] snsStateByte;
  logic [7:0] snsFaultByte;
  logic [7:0] digBase;
  logic [7:0] rdByte;
  logic       mapped;
  logic       apbAccess;
  logic       apbDone;

  // Both stages registered; only stage B feeds logic
  always_comb begin
    nxt_syncA = {sensorFault, sensorLevel, eightChLevel,
                 fourChLevel, twoChFault, twoChLevel};
    nxt_syncB = syncA_ff;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      syncA_ff <= '0;
      syncB_ff <= '0;
    end else begin
      syncA_ff <= nxt_syncA;
      syncB_ff <= nxt_syncB;
    end
  end

  assign twoLvlS   = syncB_ff[1:0];
  assign twoFltS   = syncB_ff[3:2];
  assign fourLvlS  = syncB_ff[7:4];
  assign eightLvlS = syncB_ff[15:8];
  assign snsLvlS   = syncB_ff[23:16];
  assign snsFltS   = syncB_ff[31:24];

  // One latch per diagnostic channel, independent of the other
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_diag
      dipi_chan_if chIf ();
      assign chIf.faultIn = twoFltS[gi];
      assign chIf.levelIn = twoLvlS[gi];
      assign chIf.ackIn   = ack_ff[gi];
      assign twoFlag[gi]   = chIf.flag;
      assign twoLvlOut[gi] = chIf.levelOut;
      assign twoAct[gi]    = chIf.active;
      dipi_diag_chan u_chan (
        .sys_clk (sys_clk),
        .reset_n (reset_n),
        .ch      (chIf.chan)
      );
    end
  endgenerate

  // Input image bytes
  always_comb begin
    twoInByte = 8'h00;
    twoInByte[POS_TWO_LEVEL +: 2] = twoLvlOut;
    twoInByte[POS_TWO_FLAG  +: 2] = twoFlag;
    fourInByte   = {4'h0, fourLvlS};
    eightInByte  = eightLvlS;
    // Switched-off channels report neither state nor fault
    snsStateByte = snsLvlS & ~chanOff_ff;
    snsFaultByte = snsFltS & ~chanOff_ff;
    digBase      = analogLen_ff;
  end

  // Read decode; the reserved output byte always reads zero
  always_comb begin
    rdByte = 8'h00;
    mapped = 1'b1;
    unique case (paddr)
      OFS_TWO_IN:     rdByte = twoInByte;
      OFS_TWO_ACK:    rdByte = {4'h0, ack_ff, 2'h0};
      OFS_FOUR_IN:    rdByte = fourInByte;
      OFS_EIGHT_IN:   rdByte = eightInByte;
      OFS_SNS_STATE:  rdByte = snsStateByte;
      OFS_SNS_FAULT:  rdByte = snsFaultByte;
      OFS_SNS_RSVD:   rdByte = 8'h00;
      OFS_SNS_OFF:    rdByte = chanOff_ff;
      OFS_ANALOG_LEN: rdByte = analogLen_ff;
      OFS_DIG_BASE:   rdByte = digBase;
      default:        mapped = 1'b0;
    endcase
  end

  // One wait state keeps prdata and pready straight from flops
  assign apbAccess = psel & penable;
  assign apbDone   = apbAccess & pready_ff;

  always_comb begin
    nxt_pready  = apbAccess & ~pready_ff;
    nxt_prdata  = prdata_ff;
    nxt_pslverr = 1'b0;
    if (apbAccess && !pready_ff) begin
      nxt_prdata  = pwrite ? RST_PRDATA : {24'h00_0000, rdByte};
      nxt_pslverr = ~mapped;
    end else if (apbDone) begin
      nxt_prdata  = RST_PRDATA;
    end
  end

  // Writes land only at the completing edge
  always_comb begin
    nxt_ack       = ack_ff;
    nxt_chanOff   = chanOff_ff;
    nxt_analogLen = analogLen_ff;
    if (apbDone && pwrite) begin
      unique case (paddr)
        OFS_TWO_ACK: begin
          // Bits 0 and 1 are not stored
          nxt_ack = pwdata[POS_TWO_ACK +: 2];
        end
        OFS_SNS_OFF: begin
          nxt_chanOff = pwdata[7:0];
        end
        OFS_ANALOG_LEN: begin
          nxt_analogLen = pwdata[7:0];
        end
        default: begin
          // Read-only, reserved or unmapped: write has no effect
          nxt_ack = ack_ff;
        end
      endcase
    end
  end

  // Pin outputs follow the channel state one cycle later
  always_comb begin
    nxt_twoActive = twoAct;
    nxt_chanOn    = ~chanOff_ff;
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ack_ff       <= RST_TWO_ACK;
      chanOff_ff   <= RST_SNS_OFF;
      analogLen_ff <= RST_ANALOG_LEN;
      prdata_ff    <= RST_PRDATA;
      pready_ff    <= 1'b0;
      pslverr_ff   <= 1'b0;
      twoActive_ff <= 2'h3;
      chanOn_ff    <= ~RST_SNS_OFF;
    end else begin
      ack_ff       <= nxt_ack;
      chanOff_ff   <= nxt_chanOff;
      analogLen_ff <= nxt_analogLen;
      prdata_ff    <= nxt_prdata;
      pready_ff    <= nxt_pready;
      pslverr_ff   <= nxt_pslverr;
      twoActive_ff <= nxt_twoActive;
      chanOn_ff    <= nxt_chanOn;
    end
  end

  assign prdata       = prdata_ff;
  assign pready       = pready_ff;
  assign pslverr      = pslverr_ff;
  assign twoChActive  = twoActive_ff;
  assign sensorChanOn = chanOn_ff;

endmodule : dipi_top
`default_nettype wire

// ==== dipi_top_chk_sva.sv ====
// Purpose: Port assertions for the process image top
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every instance of the top module
`default_nettype none
module dipi_top_chk
  import dipi_pkg::*;
(
  // Clock, reset and APB
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Pins
  input wire logic [1:0]  twoChFault,
  input wire logic [1:0]  twoChActive,
  input wire logic [7:0]  sensorChanOn
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Completing edge of a switch-off write
  logic offWr;
  assign offWr = pready && pwrite && paddr == OFS_SNS_OFF;
  // One wait state, single-cycle answer
  property p_wait; psel && $rose(penable) |=> pready; endproperty
  property p_one; pready |=> !pready; endproperty
  property p_bad; pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  property p_good;
    pready && paddr <= OFS_DIG_BASE && paddr[1:0] == 2'h0 |-> !pslverr;
  endproperty
  property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
  // Fault needs sync, latch and output edges, six samples cover them
  property p_fault; twoChFault[0] [*6] |-> !twoChActive[0]; endproperty
  property p_lvl;
    pready && !pwrite && paddr == OFS_TWO_IN && !twoChActive[0] |->
      prdata[2] && !prdata[0];
  endproperty
  property p_off;
    offWr |-> ##2 sensorChanOn == ~$past(pwdata[7:0], 2);
  endproperty
  property p_keep; $changed(sensorChanOn) |-> $past(offWr, 2); endproperty
  a_wait: assert property (p_wait) else $error("ready late");
  a_one: assert property (p_one) else $error("ready too long");
  a_bad: assert property (p_bad) else $error("no error");
  a_good: assert property (p_good) else $error("false error");
  a_hi: assert property (p_hi) else $error("upper bits set");
  a_fault: assert property (p_fault) else $error("no latch");
  a_lvl: assert property (p_lvl) else $error("level shown");
  a_off: assert property (p_off) else $error("switch-off wrong");
  a_keep: assert property (p_keep) else $error("stray change");
  c_off: cover property (offWr);
  c_err: cover property (pready && pslverr);
  c_lvl: cover property (pready && paddr == OFS_TWO_IN && !twoChActive[0]);
endmodule : dipi_top_chk
bind dipi_top dipi_top_chk u_chk (.sys_clk(sys_clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .twoChFault(twoChFault), .twoChActive(twoChActive),
  .sensorChanOn(sensorChanOn));
`default_nettype wire

// ==== dipi_ctrl_model.sv ====
// Purpose: Controller model that moves image bytes over APB
// Assumes: Slave answers with pready, at most 63 wait states
// Notes:   Signals change only right after a rising edge
`default_nettype none
module dipi_ctrl_model (
  // Clock and answer
  input  wire logic        sys_clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  // Request
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [7:0]  paddr,
  output var  logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
  end
  // Request held until pready seen, released only after that edge
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e, output bit late);
    int k;
    late = 1'b1;
    q = 32'h0000_0000;
    e = 1'b0;
    // Setup cycle
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    // Access phase, held until pready is seen at a rising edge
    @(posedge sys_clk);
    penable <= 1'b1;
    for (k = 0; k < 64 && late; k++) begin
      @(posedge sys_clk);
      if (pready) begin
        q    = prdata;
        e    = pslverr;
        late = 1'b0;
      end
    end
    // Released right after the completing edge
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : dipi_ctrl_model
`default_nettype wire

// ==== test_digital_input_process_image.sv ====
// Purpose: Self-checking bench for the process image top
// Assumes: Pins settle within the synchroniser delay
// Notes:   Waits after pin changes cover sync and latch edges
`default_nettype none
module test_digital_input_process_image
  import dipi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, fourX, eightLv, snsLv, snsFt, snsOn;
  logic [31:0] pwdata, prdata;
  logic [1:0] twoLv, twoFt, twoAct;
  logic [3:0] fourLv;
  int checks, n_mismatch;
  dipi_top DUT (.sys_clk(sys_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .twoChLevel(twoLv), .twoChFault(twoFt), .twoChActive(twoAct),
    .fourChLevel(fourLv), .eightChLevel(eightLv), .sensorLevel(snsLv),
    .sensorFault(snsFt), .sensorChanOn(snsOn));
  dipi_ctrl_model u_ctl (.sys_clk(sys_clk), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  // 25 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic print_verdict;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    checks++;
    if (s !== x) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  // One transfer; a write skips the data compare
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [31:0] x,
                     input logic xe);
    logic [31:0] q;
    logic e;
    bit late;
    u_ctl.xfer(w, a, d, q, e, late);
    if (late) begin
      n_mismatch++;
      print_verdict();
    end else begin
      chk({31'h0, e}, {31'h0, xe});
      if (!w) chk(q, x);
    end
  endtask : acc
  // Main sequence; fixed waits follow the synchroniser depth
  initial begin
    reset_n = 1'b0;
    twoLv = 2'h3;
    twoFt = 2'h0;
    fourLv = 4'hA;
    eightLv = 8'h5A;
    snsLv = 8'hC3;
    snsFt = 8'h81;
    repeat (16) @(posedge sys_clk);
    reset_n <= 1'b1;
    chk({30'h0, twoAct}, 32'h3);
    chk({24'h0, snsOn}, 32'hFF);
    acc(1'b0, OFS_TWO_ACK, 32'h0, 32'h0, 1'b0);
    acc(1'b0, OFS_SNS_OFF, 32'h0, 32'h0, 1'b0);
    acc(1'b0, OFS_TWO_IN, 32'h0, 32'h03, 1'b0);
    acc(1'b0, OFS_FOUR_IN, 32'h0, 32'h0A, 1'b0);
    acc(1'b0, OFS_EIGHT_IN, 32'h0, 32'h5A, 1'b0);
    acc(1'b0, OFS_SNS_STATE, 32'h0, 32'hC3, 1'b0);
    acc(1'b0, OFS_SNS_FAULT, 32'h0, 32'h81, 1'b0);
    twoFt <= 2'h1;
    repeat (6) @(posedge sys_clk);
    acc(1'b0, OFS_TWO_IN, 32'h0, 32'h06, 1'b0);
    chk({30'h0, twoAct}, 32'h2);
    twoFt <= 2'h0;
    repeat (6) @(posedge sys_clk);
    acc(1'b0, OFS_TWO_IN, 32'h0, 32'h06, 1'b0);
    acc(1'b1, OFS_TWO_ACK, 32'h04, 32'h0, 1'b0);
    repeat (3) @(posedge sys_clk);
    acc(1'b0, OFS_TWO_IN, 32'h0, 32'h03, 1'b0);
    acc(1'b0, OFS_TWO_ACK, 32'h0, 32'h04, 1'b0);
    chk({30'h0, twoAct}, 32'h3);
    twoFt <= 2'h2;
    repeat (6) @(posedge sys_clk);
    twoFt <= 2'h0;
    repeat (6) @(posedge sys_clk);
    acc(1'b0, OFS_TWO_IN, 32'h0, 32'h09, 1'b0);
    chk({30'h0, twoAct}, 32'h1);
    acc(1'b1, OFS_TWO_ACK, 32'h0C, 32'h0, 1'b0);
    repeat (3) @(posedge sys_clk);
    acc(1'b0, OFS_TWO_IN, 32'h0, 32'h03, 1'b0);
    acc(1'b1, OFS_SNS_OFF, 32'h81, 32'h0, 1'b0);
    repeat (2) @(posedge sys_clk);
    chk({24'h0, snsOn}, 32'h7E);
    acc(1'b0, OFS_SNS_STATE, 32'h0, 32'h42, 1'b0);
    acc(1'b0, OFS_SNS_FAULT, 32'h0, 32'h00, 1'b0);
    acc(1'b1, OFS_SNS_RSVD, 32'h0, 32'h0, 1'b0);
    acc(1'b0, OFS_SNS_RSVD, 32'h0, 32'h0, 1'b0);
    acc(1'b1, OFS_ANALOG_LEN, 32'h05, 32'h0, 1'b0);
    acc(1'b0, OFS_DIG_BASE, 32'h0, 32'h05, 1'b0);
    acc(1'b0, 8'h30, 32'h0, 32'h0, 1'b1);
    acc(1'b1, 8'h02, 32'hFF, 32'h0, 1'b1);
    print_verdict();
  end
endmodule : test_digital_input_process_image
`default_nettype wire
